// >>> rtl/periph_decode_pkg.sv
// Constants for the peripheral register space decoder
`default_nettype none
package periph_decode_pkg;
    // ****************************************
    // Address layout
    // ****************************************
    localparam int ADDR_W = 28;
    localparam int AREA_HI = 27;
    localparam int AREA_LO = 24;
    localparam int OFS_W = 9;
    localparam int REG_BYTES = 512;
    localparam int SHADOW_COUNT = 32768;
    localparam logic [3:0] PERIPH_AREA = 4'h5;
    localparam logic [27:0] CANON_BASE = 28'h5FFFE00;
    localparam logic [27:0] CANON_LAST = 28'h5FFFFFF;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [8:0] OFS_RESET = 9'h000;
    localparam logic [27:0] ADDR_RESET = 28'h0000000;
    // ****************************************
    // Decode states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } decode_state_type;
endpackage
`default_nettype wire

// >>> rtl/periph_offset_split.sv
// Splits a bus address into area and register offset fields
`timescale 1ns/10ps
`default_nettype none
module periph_offset_split
    import periph_decode_pkg::*;
(
    input wire logic [ADDR_W-1:0] i_addr,
    output logic [3:0] o_area,
    output logic [OFS_W-1:0] o_offset,
    output logic o_hit
);
    // ****************************************
    // Field extraction
    // ****************************************
    assign o_area = i_addr[AREA_HI:AREA_LO]; // RL4
    assign o_offset = i_addr[OFS_W-1:0]; // RL4
    assign o_hit = (o_area == PERIPH_AREA); // RL2
endmodule
`default_nettype wire

// >>> rtl/periph_space_decode.sv
// Peripheral register space address decoder
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RL1: Canonical register window is the top 512 bytes of area 5.
// RL2: Only 512 register bytes exist; address bits 23 to 9 are ignored.
// RL3: Register set mirrors into 32k shadows, each acting like the real one.
// RL4: Decode only area bits 27 to 24 and offset bits 8 to 0.
// RL5: Masters must avoid unpopulated area 5 addresses; results undefined.
module periph_space_decode
    import periph_decode_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [ADDR_W-1:0] i_addr,
    output logic o_sel,
    output logic o_wr,
    output logic [OFS_W-1:0] o_offset,
    output logic [ADDR_W-1:0] o_canon_addr,
    output logic o_busy
);
    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic is_state(input decode_state_type cur,
        input decode_state_type want);
        is_state = (cur == want);
    endfunction

    function automatic logic pick(input logic load, input logic fresh, input logic held);
        pick = load ? fresh : held;
    endfunction

    // ****************************************
    // State and output registers
    // ****************************************
    decode_state_type state_ff;
    decode_state_type nxt_state;
    logic sel_ff;
    logic wr_ff;
    logic [OFS_W-1:0] ofs_ff;
    logic [ADDR_W-1:0] canon_ff;

    // ****************************************
    // Shadow folding
    // ****************************************
    wire logic [ADDR_W-1:0] folded;
    genvar gi;

    generate
        for (gi = 0; gi < ADDR_W; gi++) begin : g_fold
            if ((gi >= OFS_W) && (gi < AREA_LO)) begin : g_drop
                assign folded[gi] = 1'b0; // RL2
            end else begin : g_keep
                assign folded[gi] = i_addr[gi]; // RL4
            end
        end
    endgenerate

    // ****************************************
    // Address split
    // ****************************************
    logic [OFS_W-1:0] offset;
    logic hit;

    periph_offset_split u_split (
        .i_addr(folded),
        .o_area(),
        .o_offset(offset),
        .o_hit(hit)
    );

    // ****************************************
    // State decode
    // ****************************************
    logic idle;
    logic hold;

    assign idle = is_state(state_ff, ST_IDLE);
    assign hold = is_state(state_ff, ST_HOLD);

    // ****************************************
    // Request take
    // ****************************************
    logic take;

    assign take = i_req & hit & idle; // RL2 RL4

    // ****************************************
    // Canonical address
    // ****************************************
    wire logic [ADDR_W-1:0] canon;

    generate
        for (gi = 0; gi < ADDR_W; gi++) begin : g_canon
            if (gi < OFS_W) begin : g_ofs_bit
                assign canon[gi] = offset[gi]; // RL3
            end else begin : g_base_bit
                assign canon[gi] = CANON_BASE[gi]; // RL1
            end
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_state = ST_IDLE;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_state = ST_HOLD;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Next register values
    // ****************************************
    logic nxt_sel;
    logic nxt_wr;
    wire logic [OFS_W-1:0] nxt_ofs;
    wire logic [ADDR_W-1:0] nxt_canon;

    assign nxt_sel = take;
    assign nxt_wr = pick(take, i_wr, wr_ff); // RL3

    // ****************************************
    // Held value selection
    // ****************************************
    generate
        for (gi = 0; gi < OFS_W; gi++) begin : g_nxt_ofs
            assign nxt_ofs[gi] = pick(take, offset[gi], ofs_ff[gi]); // RL3
        end
    endgenerate

    generate
        for (gi = 0; gi < ADDR_W; gi++) begin : g_nxt_canon
            assign nxt_canon[gi] = pick(take, canon[gi], canon_ff[gi]); // RL1
        end
    endgenerate

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Select pulse
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            sel_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
        end
    end

    // ****************************************
    // Write flag
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            wr_ff <= 1'b0;
        end else begin
            wr_ff <= nxt_wr;
        end
    end

    // ****************************************
    // Register offset
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ofs_ff <= OFS_RESET;
        end else begin
            ofs_ff <= nxt_ofs;
        end
    end

    // ****************************************
    // Canonical address register
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            canon_ff <= ADDR_RESET;
        end else begin
            canon_ff <= nxt_canon;
        end
    end

    // ****************************************
    // Select outputs
    // ****************************************
    assign o_sel = sel_ff;
    assign o_wr = wr_ff;
    assign o_offset = ofs_ff;
    assign o_canon_addr = canon_ff;

    // ****************************************
    // Status output
    // ****************************************
    assign o_busy = hold;
endmodule
`default_nettype wire

// >>> tb/periph_space_decode_monitor.sv
// Checker for the peripheral decoder
`timescale 1ns/10ps
`default_nettype none
module periph_space_decode_monitor (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [27:0] i_addr,
    input wire logic o_sel,
    input wire logic o_wr,
    input wire logic [8:0] o_offset,
    input wire logic [27:0] o_canon_addr,
    input wire logic o_busy
);
// ****************************************
// Sequences
// ****************************************
default clocking @(posedge i_mclk);
endclocking
default disable iff (!i_reset_n);
sequence take;
    i_req && i_addr[27:24] == 4'h5 && !o_busy;
endsequence
sequence sel_then_idle;
    o_sel ##1 (!o_sel && !o_busy);
endsequence
// ****************************************
// Properties
// ****************************************
chk_offset_take: assert property (take |=> o_sel && o_offset == $past(i_addr[8:0]))
    else $error("offset");
chk_canon_addr: assert property (o_sel |-> o_canon_addr == (28'h5FFFE00 | o_offset))
    else $error("canon");
chk_area_only: assert property (i_req && i_addr[27:24] != 4'h5 && !o_busy |=> !o_sel)
    else $error("area");
chk_shadow_wr: assert property (take |=> o_wr == $past(i_wr))
    else $error("wr");
chk_sel_pulse: assert property (take |=> sel_then_idle)
    else $error("sel pulse");
chk_busy_follow: assert property (o_sel |-> o_busy)
    else $error("busy");
chk_canon_window: assert property (o_sel |-> o_canon_addr[27:9] == 19'h2FFFF)
    else $error("window");
chk_shadow_canon: assert property (take |=>
    o_canon_addr == (28'h5FFFE00 | $past(i_addr[8:0])))
    else $error("shadow");
endmodule
bind periph_space_decode periph_space_decode_monitor u_mon (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_req(i_req),
    .i_wr(i_wr),
    .i_addr(i_addr),
    .o_sel(o_sel),
    .o_wr(o_wr),
    .o_offset(o_offset),
    .o_canon_addr(o_canon_addr),
    .o_busy(o_busy)
);
`default_nettype wire

// >>> tb/periph_bus_master.sv
// Bus master model
`timescale 1ns/10ps
`default_nettype none
module periph_bus_master (
    input wire logic i_mclk,
    output logic o_req,
    output logic o_wr,
    output logic [27:0] o_addr
);
// ****************************************
// Access tasks
// ****************************************
initial begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 28'h0;
end
task automatic access(input logic [27:0] a, input logic w);
    @(negedge i_mclk);
    o_req = 1'b1;
    o_wr = w;
    o_addr = a;
    @(negedge i_mclk);
    o_req = 1'b0;
    o_addr = ~a;
endtask
task automatic start(input logic [27:0] a, input logic w);
    @(negedge i_mclk);
    o_req = 1'b1;
    o_wr = w;
    o_addr = a;
endtask
task automatic stop();
    o_req = 1'b0;
    o_addr = ~o_addr;
endtask
endmodule
`default_nettype wire

// >>> tb/periph_space_decode_tb.sv
// Bench for the peripheral decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,g) begin checks++; if ((g)!==(e)) begin n_fail++; $display("Error %s %h %h",n,e,g); end end
module periph_space_decode_tb;
logic i_mclk = 0, i_reset_n = 0, i_req, i_wr, o_sel, o_wr, o_busy, w, ew = 0;
logic [27:0] i_addr, o_canon_addr, a, ec = 0;
logic [8:0] o_offset, eo = 0;
logic [9:0] q[$];
int n_fail = 0, checks = 0, cyc = 0;
initial forever #20 i_mclk = ~i_mclk;
periph_space_decode u_periph_space_decode (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_req(i_req), .i_wr(i_wr), .i_addr(i_addr), .o_sel(o_sel), .o_wr(o_wr),
    .o_offset(o_offset), .o_canon_addr(o_canon_addr), .o_busy(o_busy));
periph_bus_master u_bm (.i_mclk(i_mclk), .o_req(i_req), .o_wr(i_wr), .o_addr(i_addr));
task end_sim;
    if (n_fail == 0 && checks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
always @(posedge i_mclk) if (++cyc == 1000) begin n_fail++; end_sim; end
initial begin
    void'($urandom(32'h1effecee));
    repeat (10) @(negedge i_mclk);
    i_reset_n = 1;
    for (int k = 0; k < 40; k++) begin
        a = {($urandom % 4 == 0) ? 4'($urandom) : 4'h5, 24'($urandom)};
        w = 1'($urandom);
        u_bm.access(a, w);
        if (a[27:24] == 4'h5) begin
            q.push_back({w, a[8:0]});
        end
        if (q.size() > 0) begin
            {ew, eo} = q.pop_front();
            ec = 28'h5FFFE00 | eo;
        end
        `CHK("sel", a[27:24] == 4'h5, o_sel)
        `CHK("ofs", eo, o_offset)
        `CHK("canon", ec, o_canon_addr)
        `CHK("wr", ew, o_wr)
        `CHK("busy", a[27:24] == 4'h5, o_busy)
    end
    a = {4'h5, 24'($urandom)};
    w = 1'($urandom);
    u_bm.start(a, w);
    @(negedge i_mclk);
    `CHK("held sel", 1'b1, o_sel)
    @(negedge i_mclk);
    `CHK("refused sel", 1'b0, o_sel)
    `CHK("refused busy", 1'b0, o_busy)
    @(negedge i_mclk);
    `CHK("retake sel", 1'b1, o_sel)
    `CHK("retake ofs", a[8:0], o_offset)
    `CHK("retake wr", w, o_wr)
    u_bm.stop();
    i_reset_n = 0;
    a = {4'h5, 24'($urandom)};
    w = ~w;
    u_bm.start(a, w);
    `CHK("rst sel", 1'b0, o_sel)
    `CHK("rst busy", 1'b0, o_busy)
    `CHK("rst ofs", 9'h000, o_offset)
    `CHK("rst canon", 28'h0000000, o_canon_addr)
    `CHK("rst wr", 1'b0, o_wr)
    @(negedge i_mclk);
    i_reset_n = 1;
    @(negedge i_mclk);
    `CHK("first sel", 1'b1, o_sel)
    `CHK("first ofs", a[8:0], o_offset)
    `CHK("first canon", 28'h5FFFE00 | a[8:0], o_canon_addr)
    `CHK("first wr", w, o_wr)
    u_bm.stop();
    @(negedge i_mclk);
    end_sim;
end
endmodule
`default_nettype wire
